// ===== hdl/uart_pkg.sv
package uart_pkg;
  // Device register indexes on the link register port
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_TXSTAT = 3'h1;
  localparam logic [2:0] OFS_RXERR = 3'h2;
  localparam logic [2:0] OFS_RXBUF = 3'h3;
  localparam logic [2:0] OFS_TXBUF = 3'h4;
  localparam logic [2:0] OFS_ISC = 3'h5;
  localparam logic [2:0] OFS_CLKSEL = 3'h6;
  // Mode register fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXEN = 6;
  localparam int MODE_RXEN = 5;
  localparam int MODE_MSBF = 2;
  localparam int MODE_LEN8 = 1;
  localparam logic [7:0] MODE_RESET = 8'h01;
  // Status and routing fields
  localparam int TXSTAT_FULL = 1;
  localparam int TXSTAT_SHIFT = 0;
  localparam int RXERR_OVR = 0;
  localparam int ISC_WAKE = 0;
  localparam int ISC_CAP = 1;
  localparam logic [7:0] RXBUF_RESET = 8'hFF;
  localparam logic [7:0] TXBUF_RESET = 8'hFF;
  localparam logic [7:0] ISC_RESET = 8'h00;
  localparam logic [7:0] CLKSEL_RESET = 8'h00;
  // Base clock ticks per serial bit
  localparam int BIT_BASE_CLKS = 16;
  // Controller word addresses on the Avalon side, then interrupt event bit positions
  localparam logic [3:0] AVS_IRQ_STAT = 4'h8;
  localparam logic [3:0] AVS_IRQ_MASK = 4'h9;
  localparam int EV_TXDONE = 0;
  localparam int EV_RXDONE = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_W = 3;
endpackage

// ===== hdl/uart_link_if.sv
`timescale 1ns/10ps
interface uart_link_if;
  logic regStb;
  logic regWr;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic txDone;
  logic rxDone;
  logic txFull;
  logic baseTick;
  modport device
  (
    input regStb, regWr, regAddr, regWdata,
    output regRdata, txDone, rxDone, txFull, baseTick
  );
  modport host
  (
    output regStb, regWr, regAddr, regWdata,
    input regRdata, txDone, rxDone, txFull, baseTick
  );
endinterface

// ===== hdl/uart_data_buffer_path.sv
// Operation
// - Receive shifter deserialises pin, software cannot reach
// - Each received byte replaces receive buffer, except on overrun
// - 7-bit LSB-first fills bits 0-6, bit7 zero
// - 7-bit MSB-first fills bits 1-7, bit0 zero
// - On overrun keep buffer, drop new character
// - Receive buffer read-only, writes ignored
// - Transmit buffer write starts sending; readable back
// - Software never writes transmit buffer while full
// - Software never rewrites same value while running
// - Software waits one base clock after enable
// - First copy immediate; next copy before done pulse
// - Shifter loads and launches on base clock ticks
// - Switch bits route receive pin to wakeup, capture
// - Software times sync field to derive bit period
// - Wakeup input detects start of communication edges
// - Power off stops clock and clears logic
// - Clearing enables resets transmit or receive circuit
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module uart_data_buffer_path
  import uart_pkg::*;
#(
  parameter int BitClks = BIT_BASE_CLKS
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  uart_link_if.device link,
  input wire logic serialRxPin,
  output logic serialTxPin,
  output logic wakeupExtIrq,
  output logic timerCaptureIn
);
  localparam logic [7:0] BIT_LAST = 8'(BitClks - 1);
  localparam logic [7:0] BIT_HALF = 8'(BitClks / 2);

  logic [7:0] serialMode_q, txBuf_q, rxBuf_q, isc_q, clkSel_q;
  logic [7:0] divCnt_q, regRdata_q;
  logic baseTick_q, txFull_q, txActive_q, txDone_q;
  logic [9:0] txShift_q;
  logic [3:0] txBitCnt_q, rxBitCnt_q;
  logic [7:0] txTick_q, rxTick_q, rxShift_q;
  logic rxActive_q, rxFull_q, overrun_q, rxDone_q;
  logic rxSync1_q, rxSync2_q;
  logic serialTx_q, wakeup_q, capture_q;
  logic powerOn, txEn, rxEn, len8, msbFirst, rxIn;
  logic wrStb, rdRxBuf, rdRxErr, txLoad, txBitEnd, rxSample;
  logic [3:0] txBits, rxStopIdx;
  logic [8:0] txSeq;
  logic [7:0] rxData, txRev;

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  assign powerOn = serialMode_q[MODE_POWER];
  assign txEn = powerOn && serialMode_q[MODE_TXEN];
  assign rxEn = powerOn && serialMode_q[MODE_RXEN];
  assign len8 = serialMode_q[MODE_LEN8];
  assign msbFirst = serialMode_q[MODE_MSBF];
  assign wrStb = link.regStb && link.regWr;
  assign rdRxBuf = link.regStb && !link.regWr && link.regAddr == OFS_RXBUF;
  assign rdRxErr = link.regStb && !link.regWr && link.regAddr == OFS_RXERR;
  // Powered-down receive input reads as idle high
  assign rxIn = powerOn ? rxSync2_q : 1'b1;

  // Control registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      serialMode_q <= MODE_RESET;
      txBuf_q <= TXBUF_RESET;
      isc_q <= ISC_RESET;
      clkSel_q <= CLKSEL_RESET;
    end
    else if (clkEn && wrStb)
    begin
      unique case (link.regAddr)
        OFS_MODE: serialMode_q <= link.regWdata;
        OFS_TXBUF: txBuf_q <= link.regWdata;
        OFS_ISC: isc_q <= link.regWdata;
        OFS_CLKSEL: clkSel_q <= link.regWdata;
        default: ;
      endcase
    end
  end

  // Read-back register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      regRdata_q <= '0;
    else if (clkEn && link.regStb && !link.regWr)
    begin
      unique case (link.regAddr)
        OFS_MODE: regRdata_q <= serialMode_q;
        OFS_TXSTAT:
          regRdata_q <= {6'h00, txFull_q, txActive_q};
        OFS_RXERR: regRdata_q <= {7'h00, overrun_q};
        OFS_RXBUF: regRdata_q <= rxBuf_q;
        OFS_TXBUF: regRdata_q <= txBuf_q;
        OFS_ISC: regRdata_q <= isc_q;
        OFS_CLKSEL: regRdata_q <= clkSel_q;
        default: regRdata_q <= '0;
      endcase
    end
  end

  // Base clock: one tick stands for each falling base-clock edge
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && !powerOn))
    begin
      divCnt_q <= '0;
      baseTick_q <= 1'b0;
    end
    else if (clkEn)
    begin
      baseTick_q <= divCnt_q == clkSel_q;
      divCnt_q <= divCnt_q == clkSel_q ? 8'h00 : divCnt_q + 8'h01;
    end
  end

  // Transmit path
  assign txBits = len8 ? 4'd10 : 4'd9;
  assign txRev = reverse8(txBuf_q);
  assign txSeq = len8 ? {1'b1, msbFirst ? txRev : txBuf_q}
    : {2'b11, msbFirst ? txRev[6:0] : txBuf_q[6:0]};
  assign txBitEnd = baseTick_q && txActive_q && txTick_q == '0;
  assign txLoad = baseTick_q && txFull_q && (!txActive_q
    || (txBitEnd && txBitCnt_q == txBits - 4'd1));

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && !txEn))
    begin
      txFull_q <= 1'b0;
      txActive_q <= 1'b0;
      txDone_q <= 1'b0;
      txShift_q <= '1;
      txBitCnt_q <= '0;
      txTick_q <= '0;
    end
    else if (clkEn)
    begin
      if (wrStb && link.regAddr == OFS_TXBUF)
        txFull_q <= 1'b1;
      else if (txLoad)
        txFull_q <= 1'b0;
      txDone_q <= txBitEnd && txBitCnt_q == txBits - 4'd1;
      if (txLoad)
      begin
        txShift_q <= {txSeq, 1'b0};
        txActive_q <= 1'b1;
        txBitCnt_q <= '0;
        txTick_q <= BIT_LAST;
      end
      else if (txBitEnd)
      begin
        txShift_q <= {1'b1, txShift_q[9:1]};
        txTick_q <= BIT_LAST;
        txBitCnt_q <= txBitCnt_q + 4'd1;
        if (txBitCnt_q == txBits - 4'd1)
          txActive_q <= 1'b0;
      end
      else if (baseTick_q && txActive_q)
        txTick_q <= txTick_q - 8'h01;
    end
  end

  // Pin outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      serialTx_q <= 1'b1;
      wakeup_q <= 1'b1;
      capture_q <= 1'b1;
    end
    else if (clkEn)
    begin
      serialTx_q <= txActive_q ? txShift_q[0] : 1'b1;
      wakeup_q <= isc_q[ISC_WAKE] ? rxIn : 1'b1;
      capture_q <= isc_q[ISC_CAP] ? rxIn : 1'b1;
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rxSync1_q <= 1'b1;
      rxSync2_q <= 1'b1;
    end
    else if (clkEn)
    begin
      rxSync1_q <= serialRxPin;
      rxSync2_q <= rxSync1_q;
    end
  end

  // Receive path
  assign rxStopIdx = len8 ? 4'd9 : 4'd8;
  assign rxSample = baseTick_q && rxActive_q && rxTick_q == '0;
  always_comb
  begin
    rxData = reverse8(rxShift_q);
    if (len8)
      rxData = msbFirst ? rxData : rxShift_q;
    else if (msbFirst)
      rxData = {rxData[6:0], 1'b0};
    else
      rxData = {1'b0, rxShift_q[7:1]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && !powerOn))
    begin
      rxBuf_q <= RXBUF_RESET;
      rxFull_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!rxEn)
      begin
        rxFull_q <= 1'b0;
        overrun_q <= 1'b0;
      end
      else if (rxSample && rxBitCnt_q == rxStopIdx)
      begin
        if (rxFull_q && !rdRxBuf)
          overrun_q <= 1'b1;
        else
        begin
          rxBuf_q <= rxData;
          rxFull_q <= 1'b1;
        end
      end
      else
      begin
        if (rdRxBuf)
          rxFull_q <= 1'b0;
        if (rdRxErr)
          overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (clkEn && !rxEn))
    begin
      rxActive_q <= 1'b0;
      rxShift_q <= '1;
      rxBitCnt_q <= '0;
      rxTick_q <= '0;
      rxDone_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rxDone_q <= rxSample && rxBitCnt_q == rxStopIdx
        && !(rxFull_q && !rdRxBuf);
      if (baseTick_q && !rxActive_q && !rxIn)
      begin
        rxActive_q <= 1'b1;
        rxBitCnt_q <= '0;
        rxTick_q <= BIT_HALF;
      end
      else if (rxSample)
      begin
        rxTick_q <= BIT_LAST;
        rxBitCnt_q <= rxBitCnt_q + 4'd1;
        if ((rxBitCnt_q == '0 && rxIn) || rxBitCnt_q == rxStopIdx)
          rxActive_q <= 1'b0;
        else if (rxBitCnt_q != '0)
          rxShift_q <= {rxIn, rxShift_q[7:1]};
      end
      else if (baseTick_q && rxActive_q)
        rxTick_q <= rxTick_q - 8'h01;
    end
  end

  assign link.regRdata = regRdata_q;
  assign link.txDone = txDone_q;
  assign link.rxDone = rxDone_q;
  assign link.txFull = txFull_q;
  assign link.baseTick = baseTick_q;
  assign serialTxPin = serialTx_q;
  assign wakeupExtIrq = wakeup_q;
  assign timerCaptureIn = capture_q;
endmodule

// ===== hdl/uart_controller.sv
`timescale 1ns/10ps
module uart_controller
  import uart_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  uart_link_if.host link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  typedef enum logic [1:0] {IDLE, ISSUE, CAPTURE, DONE} state_t;
  state_t state_q;
  logic regStb_q, regWr_q, waitreq_q, irq_q, txEnReady_q, txWritten_q;
  logic [2:0] regAddr_q;
  logic [7:0] regWdata_q, modeShadow_q, txShadow_q;
  logic [31:0] readdata_q;
  logic [EV_W-1:0] status_q, mask_q, events;
  logic req, localReq, txWr, running, refuse;

  assign req = avs_read || avs_write;
  assign localReq = avs_address[3];
  assign txWr = avs_write && avs_address[2:0] == OFS_TXBUF;
  assign running = modeShadow_q[MODE_POWER]
    && (modeShadow_q[MODE_TXEN] || modeShadow_q[MODE_RXEN]);
  assign refuse = !localReq && txWr && (link.txFull
    || (running && txWritten_q && avs_writedata[7:0] == txShadow_q)
    || !txEnReady_q);

  // Request sequencing
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= IDLE;
      waitreq_q <= 1'b1;
      regStb_q <= 1'b0;
      regWr_q <= 1'b0;
      regAddr_q <= '0;
      regWdata_q <= '0;
      readdata_q <= '0;
    end
    else if (clkEn)
    begin
      regStb_q <= 1'b0;
      unique case (state_q)
        IDLE:
          if (req && (localReq || refuse))
          begin
            readdata_q <= avs_address == AVS_IRQ_STAT ? 32'(status_q)
              : avs_address == AVS_IRQ_MASK ? 32'(mask_q) : 32'h0;
            waitreq_q <= 1'b0;
            state_q <= DONE;
          end
          else if (req)
          begin
            regStb_q <= 1'b1;
            regWr_q <= avs_write;
            regAddr_q <= avs_address[2:0];
            regWdata_q <= avs_writedata[7:0];
            state_q <= ISSUE;
          end
        ISSUE: state_q <= CAPTURE;
        CAPTURE:
        begin
          readdata_q <= {24'h000000, link.regRdata};
          waitreq_q <= 1'b0;
          state_q <= DONE;
        end
        DONE:
        begin
          waitreq_q <= 1'b1;
          state_q <= IDLE;
        end
      endcase
    end
  end

  // Software-side obligations toward the transmit buffer
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      modeShadow_q <= MODE_RESET;
      txShadow_q <= TXBUF_RESET;
      txWritten_q <= 1'b0;
      txEnReady_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (state_q == IDLE && avs_write && !localReq && !refuse)
      begin
        if (avs_address[2:0] == OFS_MODE)
        begin
          modeShadow_q <= avs_writedata[7:0];
          if (!avs_writedata[MODE_TXEN] || !modeShadow_q[MODE_TXEN])
            txEnReady_q <= 1'b0;
        end
        if (txWr)
        begin
          txShadow_q <= avs_writedata[7:0];
          txWritten_q <= 1'b1;
        end
      end
      else if (link.baseTick && modeShadow_q[MODE_TXEN]
        && modeShadow_q[MODE_POWER])
        txEnReady_q <= 1'b1;
    end
  end

  // Interrupt status, mask and output
  always_comb
  begin
    events = '0;
    events[EV_TXDONE] = link.txDone;
    events[EV_RXDONE] = link.rxDone;
    events[EV_REFUSED] = state_q == IDLE && req && refuse;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end
    else if (clkEn)
    begin
      irq_q <= |(status_q & mask_q);
      if (state_q == IDLE && avs_write && avs_address == AVS_IRQ_STAT)
        status_q <= (status_q & ~avs_writedata[EV_W-1:0]) | events;
      else
        status_q <= status_q | events;
      if (state_q == IDLE && avs_write && avs_address == AVS_IRQ_MASK)
        mask_q <= avs_writedata[EV_W-1:0];
    end
  end

  assign link.regStb = regStb_q;
  assign link.regWr = regWr_q;
  assign link.regAddr = regAddr_q;
  assign link.regWdata = regWdata_q;
  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitreq_q;
  assign irq = irq_q;
endmodule

// ===== tb/uart_link_monitor.sv
`timescale 1ns/10ps
module uart_link_monitor
  import uart_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic regStb,
  input wire logic regWr,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic txDone,
  input wire logic rxDone,
  input wire logic txFull,
  input wire logic baseTick
);
  logic [7:0] mode_q;
  logic [7:0] lastTx_q;
  logic lastValid_q;
  logic tickSeen_q;
  logic txWr;
  logic modeWr;
  logic running;
  assign txWr = regStb && regWr && regAddr == OFS_TXBUF;
  assign modeWr = regStb && regWr && regAddr == OFS_MODE;
  assign running = mode_q[MODE_POWER]
    && (mode_q[MODE_TXEN] || mode_q[MODE_RXEN]);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Mirrors the mode register as forwarded to the device
  always_ff @(posedge sys_clk)
    if (sys_rst)
      mode_q <= MODE_RESET;
    else if (modeWr)
      mode_q <= regWdata;
  always_ff @(posedge sys_clk)
    if (sys_rst)
      lastValid_q <= 1'b0;
    else if (txWr)
      lastValid_q <= 1'b1;
  always_ff @(posedge sys_clk)
    if (txWr)
      lastTx_q <= regWdata;
  // Cleared when transmit enable rises, set by the next base tick
  always_ff @(posedge sys_clk)
    if (sys_rst)
      tickSeen_q <= 1'b1;
    else if (modeWr && regWdata[MODE_TXEN] && !mode_q[MODE_TXEN])
      tickSeen_q <= 1'b0;
    else if (baseTick)
      tickSeen_q <= 1'b1;
  sequence txQuiet;
    !txDone [*8];
  endsequence
  sequence rxQuiet;
    !rxDone [*8];
  endsequence
  a_tx_done_gap: assert property (txDone |=> txQuiet)
    else $error("transmit done pulses too close");
  a_rx_done_gap: assert property (rxDone |=> rxQuiet)
    else $error("receive done pulses too close");
  a_strobe_pulse: assert property (regStb |=> !regStb)
    else $error("register strobe longer than one cycle");
  a_no_full_write: assert property (txFull |-> !txWr)
    else $error("transmit buffer written while full");
  a_no_rewrite: assert property (txWr && running && lastValid_q
    |-> regWdata != lastTx_q)
    else $error("same transmit value written while running");
  a_tick_first: assert property (txWr && mode_q[MODE_TXEN]
    |-> tickSeen_q)
    else $error("transmit buffer written before a base tick");
  a_rdata_holds: assert property ((!regStb || regWr)
    |=> $stable(regRdata))
    else $error("read data changed without a read");
  a_reset_quiet: assert property (@(posedge sys_clk)
    disable iff (1'b0)
    sys_rst |=> !txDone && !rxDone && !txFull && regRdata == 8'h00)
    else $error("link outputs active after reset");
endmodule

// ===== tb/uart_data_buffer_path_tb_top.sv
`timescale 1ns/10ps
module uart_data_buffer_path_tb_top import uart_pkg::*;;
  localparam int BC = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic serialRxPin = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdv;
  logic avs_waitrequest, irq, serialTxPin, wakeupExtIrq, timerCaptureIn;
  logic [9:0] wf;
  logic [9:0] frames [4];
  int wireCnt = 0;
  int cyc = 0;
  logic clkEn = 1'b1;
  int miscompares = 0;
  int samples_checked = 0;
  uart_link_if link ();
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc++;
  uart_data_buffer_path #(.BitClks(BC)) uart_data_buffer_path_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .link(link),
    .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
    .wakeupExtIrq(wakeupExtIrq), .timerCaptureIn(timerCaptureIn));
  uart_controller uart_controller_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  uart_link_monitor uart_link_monitor_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regStb(link.regStb),
    .regWr(link.regWr), .regAddr(link.regAddr), .regWdata(link.regWdata),
    .regRdata(link.regRdata), .txDone(link.txDone), .rxDone(link.rxDone),
    .txFull(link.txFull), .baseTick(link.baseTick));
  // Samples each transmitted frame mid-bit, start bit first
  always
  begin
    @(negedge serialTxPin);
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++)
    begin
      wf[i] = serialTxPin;
      if (i < 9)
        repeat (BC) @(posedge sys_clk);
    end
    frames[wireCnt % 4] = wf;
    wireCnt++;
  end
  task automatic check(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100)
      check("waitrequest", 32'h0, 32'h1);
    @(posedge sys_clk);
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
    av(1'b0, a, 8'h00);
    check(nm, {24'h0, e}, rdv);
  endtask
  task automatic sendRx(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
    begin
      serialRxPin <= f[i];
      repeat (BC) @(posedge sys_clk);
    end
    repeat (2 * BC) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    rd("rxbuf", {1'b0, OFS_RXBUF}, RXBUF_RESET);
    rd("txbuf", {1'b0, OFS_TXBUF}, TXBUF_RESET);
    rd("mode", {1'b0, OFS_MODE}, MODE_RESET);
    rd("unmapped", 4'h7, 8'h00);
    av(1'b1, {1'b0, OFS_RXBUF}, 8'h12);
    rd("rxbuf ro", {1'b0, OFS_RXBUF}, RXBUF_RESET);
    check("pins", 32'h7,
      32'({serialTxPin, wakeupExtIrq, timerCaptureIn}));
  endtask
  task automatic t_tx;
    int k;
    av(1'b1, {1'b0, OFS_MODE}, 8'h80);
    av(1'b1, {1'b0, OFS_MODE}, 8'hE2);
    repeat (3) @(posedge sys_clk);
    av(1'b1, {1'b0, OFS_TXBUF}, 8'hA5);
    av(1'b1, {1'b0, OFS_TXBUF}, 8'h3C);
    av(1'b1, {1'b0, OFS_TXBUF}, 8'h77);
    for (k = 0; k < 2000 && wireCnt < 2; k++)
      @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    check("frame0", 32'({1'b1, 8'hA5, 1'b0}), 32'(frames[0]));
    check("frame1", 32'({1'b1, 8'h3C, 1'b0}), 32'(frames[1]));
    rd("txbuf back", {1'b0, OFS_TXBUF}, 8'h3C);
    av(1'b1, {1'b0, OFS_TXBUF}, 8'h3C);
    rd("irq stat", AVS_IRQ_STAT, 8'h05);
    repeat (60) @(posedge sys_clk);
    check("frame count", 32'd2, wireCnt);
    av(1'b1, AVS_IRQ_STAT, 8'h07);
  endtask
  task automatic t_rx;
    av(1'b1, AVS_IRQ_MASK, 8'h02);
    sendRx({1'b1, 8'h5A, 1'b0});
    check("irq", 32'h1, 32'(irq));
    sendRx({1'b1, 8'hC3, 1'b0});
    rd("overrun", {1'b0, OFS_RXERR}, 8'h01);
    rd("rxbuf kept", {1'b0, OFS_RXBUF}, 8'h5A);
    sendRx({1'b1, 8'h96, 1'b0});
    rd("rxbuf new", {1'b0, OFS_RXBUF}, 8'h96);
    av(1'b1, AVS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    check("irq masked", 32'h0, 32'(irq));
    av(1'b1, AVS_IRQ_STAT, 8'h07);
    rd("irq clear", AVS_IRQ_STAT, 8'h00);
  endtask
  task automatic t_power;
    av(1'b1, {1'b0, OFS_TXBUF}, 8'h55);
    av(1'b1, {1'b0, OFS_MODE}, 8'hA2);
    repeat (2) @(posedge sys_clk);
    rd("tx stat off", {1'b0, OFS_TXSTAT}, 8'h00);
    check("tx idle", 32'h1, 32'(serialTxPin));
    sendRx({1'b1, 8'h33, 1'b0});
    av(1'b1, {1'b0, OFS_MODE}, 8'h00);
    rd("rxbuf off", {1'b0, OFS_RXBUF}, RXBUF_RESET);
  endtask
  task automatic t_seven;
    for (int m = 0; m < 2; m++)
    begin
      av(1'b1, {1'b0, OFS_MODE}, 8'h80);
      av(1'b1, {1'b0, OFS_MODE}, (m == 1) ? 8'hA4 : 8'hA0);
      sendRx({2'b11, 7'h4B, 1'b0});
      rd("rx7", {1'b0, OFS_RXBUF}, (m == 1) ? 8'hD2 : 8'h4B);
    end
  endtask
  task automatic t_route;
    av(1'b1, {1'b0, OFS_ISC}, 8'h01);
    serialRxPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("route wake", 32'h1, 32'({wakeupExtIrq, timerCaptureIn}));
    av(1'b1, {1'b0, OFS_ISC}, 8'h02);
    check("route cap", 32'h2, 32'({wakeupExtIrq, timerCaptureIn}));
    // Clock enable low must hold the routed pin level
    clkEn <= 1'b0;
    serialRxPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("frozen cap", 32'h0, 32'(timerCaptureIn));
    clkEn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("thawed cap", 32'h1, 32'(timerCaptureIn));
  endtask
  // Sync field timed on the capture route, eight bits between first
  // and fifth falling edge
  task automatic t_lin;
    int t0;
    int t1;
    t0 = 0;
    t1 = 0;
    av(1'b1, {1'b0, OFS_ISC}, 8'h03);
    fork
      sendRx({1'b1, 8'h55, 1'b0});
      begin
        @(negedge timerCaptureIn);
        t0 = cyc;
        @(posedge sys_clk);
        check("wake edge", 32'h0, 32'(wakeupExtIrq));
        repeat (4) @(negedge timerCaptureIn);
        t1 = cyc;
      end
    join
    check("bit period", 32'(BC), 32'((t1 - t0) / 8));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_tx;
    t_rx;
    t_power;
    t_seven;
    t_route;
    t_lin;
    test_done;
  end
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end
endmodule
